// [logic/icts_regs.svh]
`ifndef ICTS_REGS_SVH
`define ICTS_REGS_SVH
// Summary of operation
// - Addressed unit blocks select-out, raises operational-in; adapters also raise integrated-unit flag.
// - Absent, unpowered or offline unit passes select-out around the loop to select-in.
// - A busy addressed unit may answer select-out with status-in instead.
// - Channel drops address-out; unit then drives its address and raises address-in.
// - Channel drives command byte with command-out; unit takes it by dropping address-in.
// - Channel drops command-out; unit then drives its status byte and raises status-in.
// - Data commands return zero status; control, test and error cases return non-zero.
// - Channel raises service-out; unit drops status-in; channel then drops service-out.
// - A unit needing service raises request-in while the channel is enabled.
// - Non-requesting units pass select-out; first requester blocks it, selects, drops request.
// - Shared request-in stays asserted while any other unit still requests.
// - Polled unit drives its address with address-in; channel checks and strobes it.
// - Channel raises command-out; unit drops address-in; then status-in carries the reason.
`define ICTS_CTRL_OFS 8'h00
`define ICTS_ADDR_OFS 8'h04
`define ICTS_STAT_OFS 8'h08
`define ICTS_REASON_OFS 8'h0C
`define ICTS_STATE_OFS 8'h10
`define ICTS_CTRL_EN 0
`define ICTS_CTRL_ADAPTER 1
`define ICTS_CTRL_REQ 2
`define ICTS_CTRL_BUSY 3
`define ICTS_CTRL_ONLINE 4
`define ICTS_CTRL_RST 5'h00
`define ICTS_ADDR_RST 8'h00
`define ICTS_STAT_RST 8'h0C
`define ICTS_REASON_RST 8'h04
`define ICTS_BUSY_STATUS 8'h10
`define ICTS_CMD_TEST 8'h00
`define ICTS_CMD_WRITE 8'h01
`define ICTS_CMD_READ 8'h02
`define ICTS_CMD_SENSE 8'h04
`define ICTS_CMD_READ_BACK 8'h0C
`define ICTS_STROBE_CYCLES 55
`endif

// [logic/icts_pkg.sv]
package icts_pkg;
	// One-hot states of the unit's tag sequencer.
	typedef enum logic [8:0] {
		ICTS_IDLE = 9'h001,
		ICTS_PASS = 9'h002,
		ICTS_WAIT_ADDR = 9'h004,
		ICTS_POLL_OP = 9'h008,
		ICTS_ADDR_IN = 9'h010,
		ICTS_CMD_TAKEN = 9'h020,
		ICTS_STATUS = 9'h040,
		ICTS_END = 9'h080,
		ICTS_BUSY = 9'h100
	} icts_state_t;
endpackage

// [logic/icts_sync.sv]
`timescale 1ns/1ps
module icts_sync #(
	parameter int W = 14
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	// Two flops per pin; the first stage feeds only the second.
	for (genvar b = 0; b < W; b++) begin : g_bit
		logic meta_q;
		logic sync_q;
		always_ff @(posedge i_clock) begin
			if (!i_rstn) begin
				meta_q <= 1'b0;
				sync_q <= 1'b0;
			end else begin
				meta_q <= i_async[b];
				sync_q <= meta_q;
			end
		end
		assign o_sync[b] = sync_q;
	end
endmodule // icts_sync

// [logic/icts_ahb_slave.sv]
`timescale 1ns/1ps
module icts_ahb_slave (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [31:0] i_rdata,
	output logic [7:0] o_raddr,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_wr_en,
	output logic [7:0] o_wr_addr,
	output logic [31:0] o_wr_data
);
	logic take;
	logic wr_pend_q;
	logic wr_pend_d;
	logic [7:0] wr_addr_q;
	logic [7:0] wr_addr_d;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;

	// An address phase is taken when selected, NONSEQ or SEQ, word sized and the bus is ready.
	assign take = i_hsel && i_htrans[1] && i_hready && (i_hsize == 3'h2);
	assign o_raddr = i_haddr[7:0];

	// Reads are registered in the address phase so data stand through the data phase.
	always_comb begin
		wr_pend_d = take && i_hwrite;
		wr_addr_d = take ? i_haddr[7:0] : wr_addr_q;
		hrdata_d = (take && !i_hwrite) ? i_rdata : hrdata_q;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q <= hrdata_d;
		end
	end

	// Zero wait states and an always OKAY response.
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = hrdata_q;
	assign o_wr_en = wr_pend_q;
	assign o_wr_addr = wr_addr_q;
	assign o_wr_data = i_hwdata;
endmodule // icts_ahb_slave

// [logic/icts_unit.sv]
`timescale 1ns/1ps
`include "icts_regs.svh"
module icts_unit
	import icts_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_select_out,
	input wire logic i_hold_out,
	input wire logic i_address_out,
	input wire logic i_command_out,
	input wire logic i_service_out,
	input wire logic i_operational_out,
	input wire logic [7:0] i_bus_out,
	output logic o_select_in,
	output logic o_operational_in,
	output logic o_address_in,
	output logic o_status_in,
	output logic o_request_in,
	output logic o_integrated_unit,
	output logic [7:0] o_bus_in,
	output logic o_bus_in_parity
);
	logic [13:0] pins_s;
	logic sel_s, hold_s, adr_s, cmd_s, srv_s, opl_s;
	logic [7:0] bus_s;
	logic [7:0] raddr;
	logic [31:0] rdata;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [4:0] ctrl_q, ctrl_d;
	logic [7:0] addr_q, addr_d, stat_q, stat_d, reason_q, reason_d;
	logic req_wr;
	icts_state_t state_q, state_d;
	logic sel_prev_q, sel_in_q, sel_in_d, op_q, op_d, adr_in_q, adr_in_d;
	logic st_in_q, st_in_d, req_q, req_d, integ_q, integ_d, poll_q, poll_d;
	logic pend_q, pend_d, par_q, par_d;
	logic [7:0] bus_q, bus_d, cmd_q, cmd_d;
	logic sel_rise, en, ours_init, ours_poll;

	// Tag-out lines and the outbound bus come from the channel's clock domain.
	icts_sync #(.W(14)) u_sync (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_async({i_bus_out, i_operational_out, i_service_out, i_command_out,
			i_address_out, i_hold_out, i_select_out}),
		.o_sync(pins_s)
	);
	assign {bus_s, opl_s, srv_s, cmd_s, adr_s, hold_s, sel_s} = pins_s;

	icts_ahb_slave u_ahb (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hsize(i_hsize),
		.i_hwdata(i_hwdata),
		.i_hready(i_hready),
		.i_rdata(rdata),
		.o_raddr(raddr),
		.o_hrdata(o_hrdata),
		.o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp),
		.o_wr_en(wr_en),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data)
	);

	// Data commands report zero status, anything else reports a non-zero byte.
	function automatic logic [7:0] status_for(input logic [7:0] cmd, input logic [7:0] st);
		logic data_cmd;
		data_cmd = (cmd == `ICTS_CMD_READ) || (cmd == `ICTS_CMD_WRITE) ||
			(cmd == `ICTS_CMD_READ_BACK) || (cmd == `ICTS_CMD_SENSE);
		if (data_cmd) begin
			return 8'h00;
		end
		return (st == 8'h00) ? `ICTS_STAT_RST : st;
	endfunction

	// Software registers: writes steer the unit, a read mux shows its state.
	always_comb begin
		ctrl_d = ctrl_q;
		addr_d = addr_q;
		stat_d = stat_q;
		reason_d = reason_q;
		req_wr = 1'b0;
		if (wr_en) begin
			case (wr_addr)
				`ICTS_CTRL_OFS: begin
					ctrl_d = wr_data[4:0];
					ctrl_d[`ICTS_CTRL_REQ] = 1'b0;
					req_wr = wr_data[`ICTS_CTRL_REQ];
				end
				`ICTS_ADDR_OFS: addr_d = wr_data[7:0];
				`ICTS_STAT_OFS: stat_d = wr_data[7:0];
				`ICTS_REASON_OFS: reason_d = wr_data[7:0];
				default: ;
			endcase
		end
		case (raddr)
			`ICTS_CTRL_OFS: rdata = {27'h0, ctrl_q};
			`ICTS_ADDR_OFS: rdata = {24'h0, addr_q};
			`ICTS_STAT_OFS: rdata = {24'h0, stat_q};
			`ICTS_REASON_OFS: rdata = {24'h0, reason_q};
			`ICTS_STATE_OFS: rdata = {cmd_q, 10'h000, poll_q, op_q, pend_q, state_q, 1'b0, bus_q[0]};
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			ctrl_q <= `ICTS_CTRL_RST;
			addr_q <= `ICTS_ADDR_RST;
			stat_q <= `ICTS_STAT_RST;
			reason_q <= `ICTS_REASON_RST;
		end else begin
			ctrl_q <= ctrl_d;
			addr_q <= addr_d;
			stat_q <= stat_d;
			reason_q <= reason_d;
		end
	end

	assign en = ctrl_q[`ICTS_CTRL_EN] && ctrl_q[`ICTS_CTRL_ONLINE];
	assign sel_rise = sel_s && !sel_prev_q;
	assign ours_init = en && adr_s && (bus_s == addr_q);
	assign ours_poll = en && !adr_s && pend_q;

	// Tag sequencer: answers selection and polling, drives tag-in lines and the inbound bus.
	always_comb begin
		state_d = state_q;
		sel_in_d = 1'b0;
		op_d = op_q;
		adr_in_d = adr_in_q;
		st_in_d = st_in_q;
		integ_d = integ_q;
		poll_d = poll_q;
		bus_d = bus_q;
		cmd_d = cmd_q;
		pend_d = pend_q;
		case (state_q)
			ICTS_IDLE: begin
				if (sel_rise && ours_init && ctrl_q[`ICTS_CTRL_BUSY]) begin
					st_in_d = 1'b1;
					bus_d = `ICTS_BUSY_STATUS;
					integ_d = ctrl_q[`ICTS_CTRL_ADAPTER];
					state_d = ICTS_BUSY;
				end else if (sel_rise && ours_init) begin
					op_d = 1'b1;
					integ_d = ctrl_q[`ICTS_CTRL_ADAPTER];
					poll_d = 1'b0;
					state_d = ICTS_WAIT_ADDR;
				end else if (sel_rise && ours_poll) begin
					op_d = 1'b1;
					integ_d = ctrl_q[`ICTS_CTRL_ADAPTER];
					pend_d = 1'b0;
					poll_d = 1'b1;
					state_d = ICTS_POLL_OP;
				end else if (sel_rise) begin
					sel_in_d = 1'b1;
					state_d = ICTS_PASS;
				end
			end
			ICTS_PASS: begin
				sel_in_d = sel_s;
				if (!sel_s) begin
					state_d = ICTS_IDLE;
				end
			end
			ICTS_WAIT_ADDR: begin
				if (!adr_s) begin
					adr_in_d = 1'b1;
					bus_d = addr_q;
					state_d = ICTS_ADDR_IN;
				end else if (!sel_s) begin
					state_d = ICTS_END;
				end
			end
			ICTS_POLL_OP: begin
				adr_in_d = 1'b1;
				bus_d = addr_q;
				state_d = ICTS_ADDR_IN;
			end
			ICTS_ADDR_IN: begin
				if (cmd_s) begin
					cmd_d = bus_s;
					adr_in_d = 1'b0;
					state_d = ICTS_CMD_TAKEN;
				end else if (!sel_s && !hold_s) begin
					adr_in_d = 1'b0;
					state_d = ICTS_END;
				end
			end
			ICTS_CMD_TAKEN: begin
				if (!cmd_s) begin
					st_in_d = 1'b1;
					bus_d = poll_q ? reason_q : status_for(cmd_q, stat_q);
					state_d = ICTS_STATUS;
				end
			end
			ICTS_STATUS: begin
				if (srv_s) begin
					st_in_d = 1'b0;
					state_d = ICTS_END;
				end
			end
			ICTS_END: begin
				if (!hold_s) begin
					op_d = 1'b0;
					integ_d = 1'b0;
					state_d = ICTS_IDLE;
				end
			end
			ICTS_BUSY: begin
				if (!sel_s) begin
					st_in_d = 1'b0;
					integ_d = 1'b0;
					state_d = ICTS_IDLE;
				end
			end
			default: state_d = ICTS_IDLE;
		endcase
		if (req_wr) begin
			pend_d = 1'b1;
		end
		req_d = pend_d && en && opl_s;
		par_d = ~^bus_d;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			state_q <= ICTS_IDLE;
			sel_prev_q <= 1'b0;
			sel_in_q <= 1'b0;
			op_q <= 1'b0;
			adr_in_q <= 1'b0;
			st_in_q <= 1'b0;
			req_q <= 1'b0;
			integ_q <= 1'b0;
			poll_q <= 1'b0;
			pend_q <= 1'b0;
			par_q <= 1'b1;
			bus_q <= 8'h00;
			cmd_q <= 8'h00;
		end else begin
			state_q <= state_d;
			sel_prev_q <= sel_s;
			sel_in_q <= sel_in_d;
			op_q <= op_d;
			adr_in_q <= adr_in_d;
			st_in_q <= st_in_d;
			req_q <= req_d;
			integ_q <= integ_d;
			poll_q <= poll_d;
			pend_q <= pend_d;
			par_q <= par_d;
			bus_q <= bus_d;
			cmd_q <= cmd_d;
		end
	end

	assign o_select_in = sel_in_q;
	assign o_operational_in = op_q;
	assign o_address_in = adr_in_q;
	assign o_status_in = st_in_q;
	assign o_request_in = req_q;
	assign o_integrated_unit = integ_q;
	assign o_bus_in = bus_q;
	assign o_bus_in_parity = par_q;

	// Checks on the sequencer's own outputs.
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	sel_block_a: assert property (o_operational_in |-> !o_select_in) else $error("select passed while selected");
	pass_loop_a: assert property (state_q == ICTS_PASS && sel_s |=> o_select_in) else $error("select not passed");
	busy_stat_a: assert property ($rose(o_status_in) && !o_operational_in |-> o_bus_in == `ICTS_BUSY_STATUS)
		else $error("busy answer lacks busy status");
	addr_answer_a: assert property (state_q == ICTS_WAIT_ADDR && !adr_s |=> o_address_in && o_bus_in == addr_q)
		else $error("address-in not raised");
	cmd_accept_a: assert property (state_q == ICTS_ADDR_IN && cmd_s |=> !o_address_in && cmd_q == $past(bus_s))
		else $error("command not accepted");
	stat_raise_a: assert property (state_q == ICTS_CMD_TAKEN && !cmd_s |=> o_status_in) else $error("status-in late");
	data_zero_a: assert property ($rose(o_status_in) && o_operational_in && !poll_q && cmd_q == `ICTS_CMD_READ
		|-> o_bus_in == 8'h00) else $error("data command status not zero");
	test_nonzero_a: assert property ($rose(o_status_in) && o_operational_in && !poll_q && cmd_q == `ICTS_CMD_TEST
		|-> o_bus_in != 8'h00) else $error("test command status zero");
	srv_drop_a: assert property (state_q == ICTS_STATUS && srv_s |=> !o_status_in ##1 !o_status_in)
		else $error("status-in not dropped");
	poll_take_a: assert property ($rose(o_operational_in) && poll_q |-> !o_request_in ##1 o_address_in)
		else $error("poll answer wrong");
	req_en_a: assert property (o_request_in |-> $past(opl_s) && pend_q) else $error("request while disabled");
endmodule // icts_unit

// [bench/icts_channel_model.sv]
`timescale 1ns/1ps
`include "icts_regs.svh"
// One processor state of the channel; the other state sequences identically.
module icts_channel_model (
	input wire logic i_clock,
	input wire logic i_select_in,
	input wire logic i_operational_in,
	input wire logic i_address_in,
	input wire logic i_status_in,
	input wire logic i_integrated_unit,
	input wire logic [7:0] i_bus_in,
	input wire logic i_bus_in_parity,
	output logic o_select_out,
	output logic o_hold_out,
	output logic o_address_out,
	output logic o_command_out,
	output logic o_service_out,
	output logic o_operational_out,
	output logic [7:0] o_bus_out
);
	int timeouts = 0;
	int perr = 0;
	logic [3:0] tin;
	// Tag-in lines gathered so that a wait can name one by index.
	assign tin = {i_select_in, i_operational_in, i_address_in, i_status_in};
	int edges = 0;
	logic [3:0] tin_q = 4'h0;
	// Every edge of a tag-in line asks the processor for a time slice; the requests are counted here.
	always @(posedge i_clock) begin
		if (!$isunknown(tin)) begin
			edges <= edges + $countones(tin ^ tin_q);
			tin_q <= tin;
		end
	end
	// Hold-out is generated from select-out, never written on its own.
	assign o_hold_out = o_select_out;
	// All tag-out lines start inactive, as after a master clear.
	initial begin
		o_select_out = 1'b0;
		o_address_out = 1'b0;
		o_command_out = 1'b0;
		o_service_out = 1'b0;
		o_operational_out = 1'b0;
		o_bus_out = 8'hA5;
	end
	// Waits a bounded time for one tag-in line to reach a level.
	task automatic await(input int idx, input logic lvl);
		int n;
		n = 0;
		while (tin[idx] !== lvl && n < 40) begin
			@(posedge i_clock);
			n++;
		end
		if (tin[idx] !== lvl)
			timeouts++;
	endtask
	// Parity is odd on the inbound bus; ignored while an adapter is selected.
	task automatic chk_par();
		if (!i_integrated_unit && i_bus_in_parity !== ~^i_bus_in)
			perr++;
	endtask
	// Changes the enable line at the next edge.
	task automatic set_oper(input logic v);
		@(posedge i_clock);
		o_operational_out <= v;
	endtask
	// One selection, initial or polling, answered whatever way the unit chooses.
	task automatic run(input logic [7:0] dev, input logic [7:0] cmd, input logic poll, input logic good,
		output logic [2:0] resp, output logic [7:0] adr, output logic [7:0] st, output logic integ);
		int n;
		n = 0;
		adr = 8'h00;
		@(posedge i_clock);
		o_operational_out <= 1'b1;
		o_bus_out <= dev;
		@(posedge i_clock);
		o_address_out <= !poll;
		@(posedge i_clock);
		o_select_out <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while ({tin[3:2], tin[0]} === 3'b000 && n < 40);
		resp = {i_select_in, i_operational_in, i_status_in};
		// A busy answer is latched only when the strobe one-shot fires.
		if (resp[0] === 1'b1)
			repeat (`ICTS_STROBE_CYCLES) @(posedge i_clock);
		integ = i_integrated_unit;
		st = i_bus_in;
		if (i_operational_in === 1'b1) begin
			o_address_out <= 1'b0;
			await(1, 1'b1);
			adr = i_bus_in;
			chk_par();
			o_bus_out <= cmd;
			o_command_out <= 1'b1;
			await(1, 1'b0);
			o_command_out <= 1'b0;
			o_bus_out <= ~cmd;
			await(0, 1'b1);
			repeat (`ICTS_STROBE_CYCLES) @(posedge i_clock);
			st = i_bus_in;
			chk_par();
			if (!good) begin
				o_select_out <= 1'b0;
				@(posedge i_clock);
			end
			o_service_out <= 1'b1;
			await(0, 1'b0);
			o_select_out <= 1'b0;
			await(2, 1'b0);
			o_service_out <= 1'b0;
		end else begin
			o_select_out <= 1'b0;
			await(resp[0] ? 0 : 3, 1'b0);
		end
		o_address_out <= 1'b0;
		o_bus_out <= ~o_bus_out;
	endtask
endmodule // icts_channel_model

// [bench/test_icts_unit.sv]
`timescale 1ns/1ps
`include "icts_regs.svh"
module test_icts_unit;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic i_hsel = 1'b0;
	logic [31:0] i_haddr = 32'h00000000;
	logic [1:0] i_htrans = 2'b00;
	logic i_hwrite = 1'b0;
	logic [2:0] i_hsize = 3'b010;
	logic [31:0] i_hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hready, hresp, sel_o, hold_o, adr_o, cmd_o, srv_o, opl_o, sel_i, opl_i, adr_i, stat_i, req_i, integ_i, par_i;
	logic [7:0] bus_o, bus_i, adr, st;
	logic [2:0] resp;
	logic integ;
	logic [31:0] rd;
	int num_errors = 0;
	int checked = 0;
	logic [7:0] cmds [6] = '{`ICTS_CMD_WRITE, `ICTS_CMD_READ, `ICTS_CMD_SENSE, `ICTS_CMD_READ_BACK,
		`ICTS_CMD_TEST, 8'h33};
	// Free-running clock at 250 MHz.
	always #2 i_clock = ~i_clock;
	icts_unit icts_unit_inst (.i_clock(i_clock), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
		.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_select_out(sel_o), .i_hold_out(hold_o),
		.i_address_out(adr_o), .i_command_out(cmd_o), .i_service_out(srv_o), .i_operational_out(opl_o),
		.i_bus_out(bus_o), .o_select_in(sel_i), .o_operational_in(opl_i), .o_address_in(adr_i),
		.o_status_in(stat_i), .o_request_in(req_i), .o_integrated_unit(integ_i), .o_bus_in(bus_i),
		.o_bus_in_parity(par_i));
	icts_channel_model icts_channel_model_inst (.i_clock(i_clock), .i_select_in(sel_i),
		.i_operational_in(opl_i), .i_address_in(adr_i), .i_status_in(stat_i), .i_integrated_unit(integ_i),
		.i_bus_in(bus_i), .i_bus_in_parity(par_i), .o_select_out(sel_o), .o_hold_out(hold_o),
		.o_address_out(adr_o), .o_command_out(cmd_o), .o_service_out(srv_o), .o_operational_out(opl_o),
		.o_bus_out(bus_o));
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("mismatches %0d, comparisons %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Compares one value and reports a difference at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One single-word transfer; the address phase is held until hready is seen high.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		@(posedge i_clock);
		i_hsel <= 1'b1;
		i_htrans <= 2'b10;
		i_haddr <= {24'h000000, a};
		i_hwrite <= wr;
		do begin
			@(posedge i_clock);
		end while (hready !== 1'b1);
		i_hsel <= 1'b0;
		i_htrans <= 2'b00;
		i_hwdata <= wd;
		do begin
			@(posedge i_clock);
		end while (hready !== 1'b1);
		r = hrdata;
	endtask
	// Hang guard, well beyond the length of the sequence below.
	initial begin
		#200000;
		num_errors++;
		conclude();
	end
	// Main sequence.
	initial begin
		repeat (6) @(posedge i_clock);
		i_rstn <= 1'b1;
		ahb(1'b0, `ICTS_CTRL_OFS, 0, rd);
		check(rd, `ICTS_CTRL_RST);
		ahb(1'b0, `ICTS_REASON_OFS, 0, rd);
		check(rd, `ICTS_REASON_RST);
		ahb(1'b0, 8'h20, 0, rd);
		check(rd, 0);
		icts_channel_model_inst.run(8'h00, 8'h01, 1'b0, 1'b1, resp, adr, st, integ);
		check(resp, 3'b100);
		ahb(1'b1, `ICTS_ADDR_OFS, 32'h5A, rd);
		ahb(1'b1, `ICTS_STAT_OFS, 32'h21, rd);
		ahb(1'b1, `ICTS_REASON_OFS, 32'h3C, rd);
		ahb(1'b1, `ICTS_CTRL_OFS, 32'h11, rd);
		ahb(1'b0, `ICTS_ADDR_OFS, 0, rd);
		check(rd, 32'h5A);
		foreach (cmds[i]) begin
			icts_channel_model_inst.run(8'h5A, cmds[i], 1'b0, 1'b1, resp, adr, st, integ);
			check(resp, 3'b010);
			check(integ, 1'b0);
			check(adr, 8'h5A);
			check(st, (i < 4) ? 8'h00 : 8'h21);
		end
		icts_channel_model_inst.run(8'h77, 8'h01, 1'b0, 1'b1, resp, adr, st, integ);
		check(resp, 3'b100);
		ahb(1'b1, `ICTS_CTRL_OFS, 32'h13, rd);
		icts_channel_model_inst.run(8'h5A, 8'h33, 1'b0, 1'b0, resp, adr, st, integ);
		check(integ, 1'b1);
		check(st, 8'h21);
		ahb(1'b1, `ICTS_CTRL_OFS, 32'h19, rd);
		icts_channel_model_inst.run(8'h5A, 8'h01, 1'b0, 1'b1, resp, adr, st, integ);
		check(resp, 3'b001);
		check(st, `ICTS_BUSY_STATUS);
		ahb(1'b1, `ICTS_CTRL_OFS, 32'h11, rd);
		icts_channel_model_inst.set_oper(1'b0);
		ahb(1'b1, `ICTS_CTRL_OFS, 32'h15, rd);
		repeat (5) @(posedge i_clock);
		check(req_i, 1'b0);
		icts_channel_model_inst.set_oper(1'b1);
		repeat (5) @(posedge i_clock);
		check(req_i, 1'b1);
		icts_channel_model_inst.run(8'hFF, 8'h01, 1'b1, 1'b0, resp, adr, st, integ);
		check(resp, 3'b010);
		check(adr, 8'h5A);
		check(st, 8'h3C);
		check(req_i, 1'b0);
		ahb(1'b0, `ICTS_STATE_OFS, 0, rd);
		check(rd, 32'h0100_2004);
		repeat (4) @(posedge i_clock);
		check(icts_channel_model_inst.edges, 54);
		check(icts_channel_model_inst.timeouts, 0);
		check(icts_channel_model_inst.perr, 0);
		conclude();
	end
endmodule // test_icts_unit
